// File: core/cfg_mem_sup_pkg.sv
// Constants for the configuration memory integrity supervisor
// ===========================================================
`default_nettype none
package cfg_mem_sup_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned PG_DEGLITCH_NS     = 60_000;
  localparam int unsigned PG_DEGLITCH_CYC    =
    (PG_DEGLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SHARE_CLK_HZ       = 100_000;
  localparam int unsigned SHARE_HALF_CYC     =
    CLK_HZ / (2 * SHARE_CLK_HZ);
  // ==========================================================
  // Bus addresses (7 bit)
  localparam logic [6:0]  ADDR_RECOVERY      = 7'h7C;
  localparam logic [6:0]  ADDR_GLOBAL_A      = 7'h5A;
  localparam logic [6:0]  ADDR_GLOBAL_B      = 7'h5B;
  localparam logic [6:0]  OWN_ADDR_RST       = 7'h40;
  // ==========================================================
  // Die temperature thresholds, degrees C (130 and 125)
  localparam logic [7:0]  TEMP_LOCK_C        = 8'h82;
  localparam logic [7:0]  TEMP_RELEASE_C     = 8'h7D;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_PAGE           = 8'h04;
  localparam logic [7:0]  REG_CMD            = 8'h08;
  localparam logic [7:0]  REG_STATUS_WORD    = 8'h0C;
  localparam logic [7:0]  REG_MFR_STATUS     = 8'h10;
  localparam logic [7:0]  REG_FLT_CFG        = 8'h14;
  localparam logic [7:0]  REG_OWN_ADDR       = 8'h18;
  localparam logic [7:0]  REG_PINS           = 8'h1C;
  // ==========================================================
  // Field positions
  localparam int unsigned STAT_CML_BIT       = 1;
  localparam int unsigned STAT_OFF_BIT       = 6;
  localparam int unsigned MFR_CRC_BIT        = 0;
  localparam int unsigned MFR_LOCK_BIT       = 1;
  localparam int unsigned MFR_READY_BIT      = 2;
  localparam int unsigned MFR_WP_BIT         = 3;
  localparam int unsigned MFR_FLT_BIT        = 4;
  localparam int unsigned FLT_LATCH_BIT      = 8;
  localparam logic [31:0] PAGE_MAX           = 32'h0000_0001;
  // ==========================================================
  // Command codes
  localparam logic [7:0]  CMD_CLEAR_FAULTS   = 8'h03;
  localparam logic [7:0]  CMD_STORE_ALL      = 8'h15;
  localparam logic [7:0]  CMD_RESTORE_ALL    = 8'h16;
  localparam logic [7:0]  CMD_VENDOR_RESET   = 8'hFD;
  // ==========================================================
  // CRC-8 over the memory image, check byte appended
  localparam logic [7:0]  CRC_POLY           = 8'h07;
  localparam logic [7:0]  CRC_INIT           = 8'h00;
  // Load sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ  = 3'b010,
    ST_LOAD = 3'b100
  } load_state_t;
endpackage
`default_nettype wire

// File: core/config_memory_integrity_supervisor.sv
// Configuration memory integrity supervisor with APB register slave
`default_nettype none
module config_memory_integrity_supervisor #(
  parameter int unsigned FLT_W  = 4,
  parameter int unsigned PG_CYC = cfg_mem_sup_pkg::PG_DEGLITCH_CYC,
  parameter int unsigned SC_HALF = cfg_mem_sup_pkg::SHARE_HALF_CYC
) (
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  input  wire logic [7:0]        PADDR_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  output logic                   MEM_RD_REQ_O,
  output logic                   MEM_WR_REQ_O,
  input  wire logic              MEM_VALID_I,
  input  wire logic [7:0]        MEM_DATA_I,
  input  wire logic              MEM_LAST_I,
  input  wire logic [7:0]        DIE_TEMP_I,
  input  wire logic              WP_I,
  input  wire logic [6:0]        BUS_ADDR_I,
  output logic                   ADDR_ACK_O,
  input  wire logic [FLT_W-1:0]  FAULT_SRC_I,
  input  wire logic [1:0]        OVUV_I,
  input  wire logic [1:0]        RUN_I,
  output logic      [1:0]        RUN_O,
  output logic      [1:0]        RUN_OEN_O,
  output logic      [1:0]        PGOOD_O,
  output logic      [1:0]        PGOOD_OEN_O,
  input  wire logic              ALERT_I,
  output logic                   ALERT_O,
  output logic                   ALERT_OEN_O,
  input  wire logic              SHARE_CLK_I,
  output logic                   SHARE_CLK_O,
  output logic                   SHARE_CLK_OEN_O
);
  import cfg_mem_sup_pkg::*;

  localparam int unsigned SW  = FLT_W + 7;
  localparam int unsigned PGW = $clog2(PG_CYC + 1);
  localparam int unsigned SCW = $clog2(2 * SC_HALF + 1);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == REG_CTRL || a == REG_PAGE || a == REG_CMD ||
           a == REG_STATUS_WORD || a == REG_MFR_STATUS ||
           a == REG_FLT_CFG || a == REG_OWN_ADDR || a == REG_PINS;
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [SW-1:0]    s1_r;
  logic [SW-1:0]    s2_r;
  logic             wp_s;
  logic [FLT_W-1:0] flt_s;
  logic [1:0]       ovuv_s;
  logic [1:0]       run_s;
  logic             alert_s;
  logic             sc_s;

  // Two stages before logic sees the WP, fault, OVUV, run, alert and share pins
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {WP_I, FAULT_SRC_I, OVUV_I, RUN_I, ALERT_I, SHARE_CLK_I};
      s2_r <= s1_r;
    end
  end
  assign {wp_s, flt_s, ovuv_s, run_s, alert_s, sc_s} = s2_r;

  // ==========================================================
  // Register state
  load_state_t      st_r;
  logic [7:0]       crc_r;
  logic             ready_r;
  logic             crc_err_r;
  logic             lock_r;
  logic [1:0]       chan_on_r;
  logic             page_r;
  logic [FLT_W-1:0] flt_mask_r;
  logic             latch_mode_r;
  logic             flt_latched_r;
  logic [6:0]       own_addr_r;
  logic             mem_wr_r;
  logic [31:0]      prdata_r;
  logic             err;
  logic             acc;
  logic             wok;
  logic             cmd_ok;
  logic             cmd_wr;
  logic             clr_faults;
  logic             load_go;
  logic             load_pass;
  logic             load_fail;
  logic [7:0]       crc_nxt;
  logic [FLT_W-1:0] flt_act;
  logic             shutdown;
  logic             run_allow;
  logic [1:0]       run_en;
  logic [1:0]       pg_ok_r;

  // ==========================================================
  // APB decode; zero wait states
  assign acc      = PSEL_I & PENABLE_I;
  assign PREADY_O = 1'b1;

  // Which command may run now
  always_comb begin
    unique case (PWDATA_I[7:0])
      CMD_CLEAR_FAULTS: cmd_ok = 1'b1;
      CMD_STORE_ALL:    cmd_ok = !wp_s && !lock_r && st_r == ST_IDLE;
      CMD_RESTORE_ALL,
      CMD_VENDOR_RESET: cmd_ok = st_r == ST_IDLE;
      default:          cmd_ok = 1'b0;
    endcase
  end

  // Error answer; refused writes leave all state alone
  always_comb begin
    err = 1'b0;
    if (acc) begin
      if (!mapped(PADDR_I)) begin
        err = 1'b1;
      end else if (PWRITE_I) begin
        unique case (PADDR_I)
          REG_CTRL, REG_FLT_CFG, REG_OWN_ADDR: err = wp_s;
          REG_PAGE:       err = PWDATA_I > PAGE_MAX;
          REG_CMD:        err = !cmd_ok;
          REG_MFR_STATUS: err = 1'b0;
          default:        err = 1'b1;
        endcase
      end
    end
  end
  assign PSLVERR_O  = err;
  assign wok        = acc & PWRITE_I & ~err;
  assign cmd_wr     = wok && PADDR_I == REG_CMD;
  assign clr_faults = (cmd_wr && PWDATA_I[7:0] == CMD_CLEAR_FAULTS) ||
                      (wok && PADDR_I == REG_MFR_STATUS &&
                       PWDATA_I[MFR_CRC_BIT]);
  assign load_go    = cmd_wr && (PWDATA_I[7:0] == CMD_RESTORE_ALL ||
                                 PWDATA_I[7:0] == CMD_VENDOR_RESET);

  // Software-written configuration
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      chan_on_r    <= '0;
      page_r       <= 1'b0;
      flt_mask_r   <= '0;
      latch_mode_r <= 1'b0;
      own_addr_r   <= OWN_ADDR_RST;
    end else if (wok) begin
      unique case (PADDR_I)
        REG_CTRL:     chan_on_r[page_r] <= PWDATA_I[0];
        REG_PAGE:     page_r <= PWDATA_I[0];
        REG_FLT_CFG: begin
          flt_mask_r   <= PWDATA_I[FLT_W-1:0];
          latch_mode_r <= PWDATA_I[FLT_LATCH_BIT];
        end
        REG_OWN_ADDR: own_addr_r <= PWDATA_I[6:0];
        default: ;
      endcase
    end
  end

  // Read data captured in the setup phase so it is a flop
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prdata_r <= '0;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      prdata_r <= '0;
      unique case (PADDR_I)
        REG_CTRL:        prdata_r[0] <= chan_on_r[page_r];
        REG_PAGE:        prdata_r[0] <= page_r;
        REG_STATUS_WORD: begin
          prdata_r[STAT_CML_BIT] <= crc_err_r;
          prdata_r[STAT_OFF_BIT] <= !run_en[page_r];
        end
        REG_MFR_STATUS: begin
          prdata_r[MFR_CRC_BIT]   <= crc_err_r;
          prdata_r[MFR_LOCK_BIT]  <= lock_r;
          prdata_r[MFR_READY_BIT] <= ready_r;
          prdata_r[MFR_WP_BIT]    <= wp_s;
          prdata_r[MFR_FLT_BIT]   <= flt_latched_r;
        end
        REG_FLT_CFG: begin
          prdata_r[FLT_W-1:0]     <= flt_mask_r;
          prdata_r[FLT_LATCH_BIT] <= latch_mode_r;
        end
        REG_OWN_ADDR:    prdata_r[6:0] <= own_addr_r;
        REG_PINS:        prdata_r[SW-1:0] <= s2_r;
        default: ;
      endcase
    end
  end
  assign PRDATA_O = prdata_r;

  // ==========================================================
  // Memory load and CRC check
  assign crc_nxt   = crc8(crc_r, MEM_DATA_I);
  assign load_pass = st_r == ST_LOAD && MEM_VALID_I && MEM_LAST_I &&
                     crc_nxt == 8'h00;
  assign load_fail = st_r == ST_LOAD && MEM_VALID_I && MEM_LAST_I &&
                     crc_nxt != 8'h00;
  assign MEM_RD_REQ_O = st_r == ST_REQ;

  // Reset state starts a load, as do the reload commands
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r  <= ST_REQ;
      crc_r <= CRC_INIT;
    end else begin
      unique case (st_r)
        ST_IDLE: if (load_go) st_r <= ST_REQ;
        ST_REQ: begin
          crc_r <= CRC_INIT;
          st_r  <= ST_LOAD;
        end
        ST_LOAD: if (MEM_VALID_I) begin
          crc_r <= crc_nxt;
          if (MEM_LAST_I) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Controller stays in reset until an image checks good
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ready_r <= 1'b0;
    end else if (load_pass) begin
      ready_r <= 1'b1;
    end else if (st_r == ST_REQ) begin
      ready_r <= 1'b0;
    end
  end

  // Sticky CRC error; a new failure beats any clear
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      crc_err_r <= 1'b0;
    end else if (load_fail) begin
      crc_err_r <= 1'b1;
    end else if (clr_faults || load_pass) begin
      crc_err_r <= 1'b0;
    end
  end

  // Store pulse, only issued when allowed by cmd_ok
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mem_wr_r <= 1'b0;
    end else begin
      mem_wr_r <= cmd_wr && PWDATA_I[7:0] == CMD_STORE_ALL;
    end
  end
  assign MEM_WR_REQ_O = mem_wr_r;

  // Thermal lockout with hysteresis
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_r <= 1'b0;
    end else if (DIE_TEMP_I > TEMP_LOCK_C) begin
      lock_r <= 1'b1;
    end else if (DIE_TEMP_I < TEMP_RELEASE_C) begin
      lock_r <= 1'b0;
    end
  end

  // ==========================================================
  // Address acknowledge for the serial front end
  assign ADDR_ACK_O = BUS_ADDR_I == own_addr_r ||
                      BUS_ADDR_I == ADDR_GLOBAL_A ||
                      BUS_ADDR_I == ADDR_GLOBAL_B ||
                      (crc_err_r && BUS_ADDR_I == ADDR_RECOVERY);

  // ==========================================================
  // Fault shutdown
  assign flt_act  = flt_s & ~flt_mask_r;
  assign shutdown = flt_latched_r | (|flt_act);

  // Latched mode holds off until faults are cleared
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flt_latched_r <= 1'b0;
    end else if (latch_mode_r && |flt_act) begin
      flt_latched_r <= 1'b1;
    end else if (clr_faults) begin
      flt_latched_r <= 1'b0;
    end
  end

  // Any CRC failure holds both enables low
  assign run_allow = ready_r & ~crc_err_r & (st_r == ST_IDLE);
  assign run_en    = chan_on_r & {2{run_allow & ~shutdown}};

  // Enable pins and alert; enable low means pulling the wire low
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RUN_OEN_O   <= 2'b00;
      ALERT_OEN_O <= 1'b1;
    end else begin
      RUN_OEN_O   <= run_en;
      ALERT_OEN_O <= ~(crc_err_r | flt_latched_r);
    end
  end
  assign RUN_O   = 2'b00;
  assign ALERT_O = 1'b0;
  assign PGOOD_O = 2'b00;

  // ==========================================================
  // Power good deglitch, one filter per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_pg
    logic [PGW-1:0] cnt_r;
    // Change accepted only after the window holds steady
    always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
        cnt_r      <= '0;
        pg_ok_r[ch] <= 1'b0;
      end else if (pg_ok_r[ch] == !ovuv_s[ch]) begin
        cnt_r <= '0;
      end else if (cnt_r == PGW'(PG_CYC - 1)) begin
        cnt_r       <= '0;
        pg_ok_r[ch] <= !ovuv_s[ch];
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
  // Held low while off, so a stopped rail never reads good
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PGOOD_OEN_O <= 2'b00;
    end else begin
      PGOOD_OEN_O <= pg_ok_r & run_en;
    end
  end

  // ==========================================================
  // Shared timebase: low half then released half
  logic [SCW-1:0] sc_cnt_r;
  logic           sc_prev_r;

  // An outside falling edge restarts the period, so all
  // parts on the wire end up following the fastest one
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sc_cnt_r  <= '0;
      sc_prev_r <= 1'b0;
    end else begin
      sc_prev_r <= sc_s;
      if (sc_prev_r && !sc_s && sc_cnt_r >= SCW'(SC_HALF)) begin
        sc_cnt_r <= '0;
      end else if (sc_cnt_r == SCW'(2 * SC_HALF - 1)) begin
        sc_cnt_r <= '0;
      end else begin
        sc_cnt_r <= sc_cnt_r + 1'b1;
      end
    end
  end
  // Wire held low until the part has initialised
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SHARE_CLK_OEN_O <= 1'b0;
    end else begin
      SHARE_CLK_OEN_O <= ready_r && sc_cnt_r >= SCW'(SC_HALF);
    end
  end
  assign SHARE_CLK_O = 1'b0;
endmodule
`default_nettype wire

// File: tb/cfg_mem_sup_props.sv
// Port-level assertions for the memory integrity supervisor
`default_nettype none
module cfg_mem_sup_props (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PSLVERR_O,
  input wire logic        MEM_RD_REQ_O,
  input wire logic        MEM_WR_REQ_O,
  input wire logic        MEM_VALID_I,
  input wire logic [7:0]  DIE_TEMP_I,
  input wire logic        WP_I,
  input wire logic [6:0]  BUS_ADDR_I,
  input wire logic        ADDR_ACK_O,
  input wire logic [1:0]  RUN_OEN_O,
  input wire logic        ALERT_OEN_O
);
  import cfg_mem_sup_pkg::*;
  // ==========================================================
  // Decodes shared by several properties
  logic wr_acc;
  logic cmd_wr;
  logic rcv;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign cmd_wr = wr_acc && PADDR_I == REG_CMD;
  assign rcv    = BUS_ADDR_I == ADDR_RECOVERY;
  // ==========================================================
  // Assertions; run and alert outputs lag the fault flag by one cycle
  default clocking dc @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_recov_fail: assert property ((rcv && ADDR_ACK_O)[*2] |->
    !ALERT_OEN_O && RUN_OEN_O == 2'b00)
    else $error("recovery ack while alert or rails released");
  a_recov_closed: assert property (rcv ##1 ALERT_OEN_O |->
    !$past(ADDR_ACK_O))
    else $error("recovery address answered without fault");
  a_global_ack: assert property (BUS_ADDR_I == ADDR_GLOBAL_A ||
    BUS_ADDR_I == ADDR_GLOBAL_B |-> ADDR_ACK_O)
    else $error("global address not answered");
  a_wp_block: assert property (WP_I[*3] ##0
    (wr_acc && PADDR_I == REG_CTRL) |-> PSLVERR_O)
    else $error("control write taken while protected");
  a_reload_req: assert property (cmd_wr && !PSLVERR_O &&
    PWDATA_I[7:0] == CMD_RESTORE_ALL |=> MEM_RD_REQ_O ##1 !MEM_RD_REQ_O)
    else $error("restore did not start one load request");
  a_hot_store: assert property ((DIE_TEMP_I > TEMP_LOCK_C)[*2] ##0
    (cmd_wr && PWDATA_I[7:0] == CMD_STORE_ALL) |-> PSLVERR_O ##1
    !MEM_WR_REQ_O)
    else $error("store accepted above lock temperature");
  a_page_range: assert property (wr_acc && PADDR_I == REG_PAGE &&
    PWDATA_I > PAGE_MAX |-> PSLVERR_O)
    else $error("page above one accepted");
  a_alert_hold: assert property (
    (!ALERT_OEN_O && !PSEL_I && !MEM_VALID_I)[*2] |=> !ALERT_OEN_O)
    else $error("alert released without clearing event");
  a_store_pulse: assert property (cmd_wr && !PSLVERR_O &&
    PWDATA_I[7:0] == CMD_STORE_ALL |=> MEM_WR_REQ_O ##1 !MEM_WR_REQ_O)
    else $error("accepted store gave no single write request");
  c_crc_fail: cover property (rcv && ADDR_ACK_O);
  c_reload: cover property (MEM_RD_REQ_O);
  c_refused: cover property (wr_acc && PSLVERR_O);
endmodule
bind config_memory_integrity_supervisor cfg_mem_sup_props u_props (
  .CLK_I(CLK_I), .RST_I(RST_I), .PADDR_I(PADDR_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PWDATA_I(PWDATA_I),
  .PSLVERR_O(PSLVERR_O), .MEM_RD_REQ_O(MEM_RD_REQ_O),
  .MEM_WR_REQ_O(MEM_WR_REQ_O), .MEM_VALID_I(MEM_VALID_I),
  .DIE_TEMP_I(DIE_TEMP_I), .WP_I(WP_I), .BUS_ADDR_I(BUS_ADDR_I),
  .ADDR_ACK_O(ADDR_ACK_O), .RUN_OEN_O(RUN_OEN_O),
  .ALERT_OEN_O(ALERT_OEN_O));
`default_nettype wire

// File: tb/mem_image_model.sv
// Behavioural memory image that streams bytes plus a CRC-8 check byte
`default_nettype none
module mem_image_model #(
  parameter int unsigned LEN = 4
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic       bad_i,
  input  wire logic       slow_i,
  output logic            valid_o,
  output logic            last_o,
  output logic      [7:0] data_o
);
  logic [2:0] cnt_r;
  logic       busy_r;
  logic       tick_r;
  logic [7:0] crc_r;
  // MSB-first CRC-8, poly 07, one byte at a time
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction
  // Stream; idle data toggles so a stale byte never looks valid
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {busy_r, tick_r, valid_o, last_o} <= '0;
      cnt_r <= '0;
      crc_r <= '0;
      data_o <= 8'h5A;
    end else begin
      valid_o <= 1'b0;
      last_o <= 1'b0;
      data_o <= ~data_o;
      tick_r <= ~tick_r;
      if (req_i && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r <= '0;
        crc_r <= '0;
      end else if (busy_r && (!slow_i || tick_r)) begin
        valid_o <= 1'b1;
        cnt_r <= cnt_r + 3'd1;
        if (cnt_r == 3'(LEN)) begin
          data_o <= crc_r ^ {7'b0, bad_i};
          last_o <= 1'b1;
          busy_r <= 1'b0;
        end else begin
          data_o <= 8'h31 + {5'b0, cnt_r};
          crc_r <= crc8(crc_r, 8'h31 + {5'b0, cnt_r});
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/config_memory_integrity_supervisor_test.sv
// Self-checking bench for the memory integrity supervisor
`default_nettype none
module config_memory_integrity_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cfg_mem_sup_pkg::*;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;
  } row_t;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, e;
  logic        wp = 0, bad = 0, slow = 0, pready, perr, ack;
  logic        rd_req, wr_req, mvalid, mlast, alert_oen, sc_oen;
  logic [7:0]  paddr = 0, temp = 8'h19, mdata;
  logic [31:0] pwdata = 0, prdata, q;
  logic [6:0]  baddr = 7'h00;
  logic [3:0]  fsrc = 0;
  logic [1:0]  ovuv = 0, run_oen, pg_oen;
  int          checks = 0, n_fail = 0, n;
  logic [7:0]  tt [4] = '{8'h82, 8'h83, 8'h7D, 8'h7C};
  logic        tl [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  row_t        rows [12] = '{
    '{1'b0, REG_MFR_STATUS, '0, 32'h0000_0004, 1'b0},
    '{1'b0, REG_OWN_ADDR, '0, 32'h0000_0040, 1'b0},
    '{1'b1, REG_PAGE, 32'h0000_0002, '0, 1'b1},
    '{1'b1, REG_PAGE, 32'h0000_0001, '0, 1'b0},
    '{1'b0, REG_PAGE, '0, 32'h0000_0001, 1'b0},
    '{1'b1, REG_CTRL, 32'h0000_0001, '0, 1'b0},
    '{1'b1, REG_PAGE, '0, '0, 1'b0},
    '{1'b1, REG_CTRL, 32'h0000_0001, '0, 1'b0},
    '{1'b1, REG_STATUS_WORD, '0, '0, 1'b1},
    '{1'b0, 8'h20, '0, '0, 1'b1},
    '{1'b1, REG_CMD, 32'h0000_0055, '0, 1'b1},
    '{1'b0, REG_STATUS_WORD, '0, '0, 1'b0}};
  // Open-drain lines: pull-up, only this device drives them
  config_memory_integrity_supervisor #(.PG_CYC(8), .SC_HALF(4)) dut (
    .CLK_I(clk), .RST_I(rst), .PADDR_I(paddr), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
    .MEM_RD_REQ_O(rd_req), .MEM_WR_REQ_O(wr_req), .MEM_VALID_I(mvalid),
    .MEM_DATA_I(mdata), .MEM_LAST_I(mlast), .DIE_TEMP_I(temp),
    .WP_I(wp), .BUS_ADDR_I(baddr), .ADDR_ACK_O(ack), .FAULT_SRC_I(fsrc),
    .OVUV_I(ovuv), .RUN_I(run_oen), .RUN_O(), .RUN_OEN_O(run_oen),
    .PGOOD_O(), .PGOOD_OEN_O(pg_oen), .ALERT_I(alert_oen), .ALERT_O(),
    .ALERT_OEN_O(alert_oen), .SHARE_CLK_I(sc_oen), .SHARE_CLK_O(),
    .SHARE_CLK_OEN_O(sc_oen));
  mem_image_model mem (.clk_i(clk), .rst_i(rst), .req_i(rd_req),
    .bad_i(bad), .slow_i(slow), .valid_o(mvalid), .last_o(mlast),
    .data_o(mdata));
  // 20 MHz clock
  always #25 clk = ~clk;
  // ==========================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] s, x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // APB transfer; extra edge so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait for run enables and alert to reach a level
  task automatic settle(input logic [2:0] t);
    n = 0;
    while ({run_oen, alert_oen} !== t && n < 60) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      baddr <= i == 0 ? ADDR_RECOVERY : i == 1 ? ADDR_GLOBAL_A : ADDR_GLOBAL_B;
      @(posedge clk);
      chk("addr_ack", {31'b0, ack}, {31'b0, i != 0});
    end
    baddr <= ADDR_RECOVERY;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", {31'b0, e}, {31'b0, rows[i].e});
      if (!rows[i].w) chk("prdata", q, rows[i].q);
    end
    settle(3'b111);
    chk("run_on", {29'b0, run_oen, alert_oen}, 32'h0000_0007);
    // Timebase released for half of each period once initialised
    n = 0;
    repeat (16) begin
      @(posedge clk);
      n += sc_oen;
    end
    chk("share_duty", n, 32'h0000_0008);
    // Deglitch: short excursion ignored, long one drops channel 1
    repeat (20) @(posedge clk);
    chk("pgood", {30'b0, pg_oen}, 32'h0000_0003);
    ovuv <= 2'b10;
    repeat (3) @(posedge clk);
    ovuv <= 2'b00;
    repeat (20) @(posedge clk);
    chk("pg_glitch", {30'b0, pg_oen}, 32'h0000_0003);
    ovuv <= 2'b10;
    repeat (20) @(posedge clk);
    chk("pg_drop", {30'b0, pg_oen}, 32'h0000_0001);
    ovuv <= 2'b00;
    // Failing reload, sticky flags, then clear
    bad <= 1'b1;
    apb(1'b1, REG_CMD, {24'b0, CMD_RESTORE_ALL});
    settle(3'b000);
    repeat (10) @(posedge clk);
    chk("crc_pins", {29'b0, run_oen, alert_oen}, '0);
    chk("ack_rcv", {31'b0, ack}, 32'h0000_0001);
    apb(1'b0, REG_STATUS_WORD, '0);
    chk("status", q, 32'h0000_0042);
    apb(1'b0, REG_MFR_STATUS, '0);
    chk("mfr", q, 32'h0000_0001);
    bad <= 1'b0;
    // Repair as the host would, on a cool die: store, then clear
    apb(1'b1, REG_CMD, {24'b0, CMD_STORE_ALL});
    chk("repair_store", {31'b0, e}, '0);
    apb(1'b1, REG_CMD, {24'b0, CMD_CLEAR_FAULTS});
    settle(3'b001);
    chk("cleared", {28'b0, run_oen, alert_oen, ack}, 32'h0000_0002);
    // Write protect: control write and store refused, restore still allowed
    wp <= 1'b1;
    slow <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b1, REG_CTRL, '0);
    chk("wp_ctrl", {31'b0, e}, 32'h0000_0001);
    apb(1'b1, REG_CMD, {24'b0, CMD_STORE_ALL});
    chk("wp_store", {31'b0, e}, 32'h0000_0001);
    apb(1'b1, REG_CMD, {24'b0, CMD_RESTORE_ALL});
    settle(3'b111);
    chk("restored", {28'b0, run_oen, alert_oen, e}, 32'h0000_000E);
    wp <= 1'b0;
    slow <= 1'b0;
    // Thermal lockout with hysteresis
    for (int i = 0; i < 4; i++) begin
      temp <= tt[i];
      repeat (3) @(posedge clk);
      apb(1'b1, REG_CMD, {24'b0, CMD_STORE_ALL});
      chk("hot_store", {31'b0, e}, {31'b0, tl[i]});
    end
    temp <= 8'h19;
    // Masked source ignored, latched source holds shutdown
    apb(1'b1, REG_FLT_CFG, 32'h0000_0102);
    fsrc <= 4'b0010;
    repeat (8) @(posedge clk);
    chk("masked", {29'b0, run_oen, alert_oen}, 32'h0000_0007);
    fsrc <= 4'b0001;
    repeat (6) @(posedge clk);
    fsrc <= 4'b0000;
    repeat (8) @(posedge clk);
    chk("latched", {29'b0, run_oen, alert_oen}, '0);
    apb(1'b1, REG_CMD, {24'b0, CMD_CLEAR_FAULTS});
    settle(3'b111);
    chk("unlatch", {29'b0, run_oen, alert_oen}, 32'h0000_0007);
    // Unlatched mode: rails off only while the fault stands
    apb(1'b1, REG_FLT_CFG, '0);
    fsrc <= 4'b0001;
    repeat (6) @(posedge clk);
    chk("retry_off", {29'b0, run_oen, alert_oen}, 32'h0000_0001);
    fsrc <= 4'b0000;
    settle(3'b111);
    chk("retry_on", {29'b0, run_oen, alert_oen}, 32'h0000_0007);
    // Failing power-on load keeps channels held
    bad <= 1'b1;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (40) @(posedge clk);
    // Channel switched on, yet the failed image must keep it held
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    apb(1'b0, REG_MFR_STATUS, '0);
    chk("por_mfr", q, 32'h0000_0001);
    chk("por_fail", {29'b0, run_oen, alert_oen}, '0);
    wrap_up();
  end
endmodule
`default_nettype wire
